/* design/mqb_pkg.sv */
// shared constants and types for the message queue and barrier sync block
package mqb_pkg;
  // ---------------------------------------------------------------
  // data path and node numbering
  // ---------------------------------------------------------------
  localparam int W = 64;
  localparam int NODE_W = 3;
  localparam int NODES = 8;
  localparam int SYNC_BITS = 16;
  localparam int BANK_BITS = 8;
  localparam int MSG_WORDS = 4;
  localparam int PAR_W = 4;
  // ---------------------------------------------------------------
  // queue geometry in local memory
  // ---------------------------------------------------------------
  localparam int QSLOTS = 4080;
  localparam int QSPARE = 16;
  localparam int QTOTAL = QSLOTS + QSPARE;
  localparam int SLOT_BYTES = 64;
  localparam int QBYTES = QTOTAL * SLOT_BYTES;
  localparam int PTR_W = 12;
  localparam int CNT_W = 13;
  localparam int IDX_W = 3;
  localparam int BYTE_W = 3;
  localparam int MEM_AW = 18;
  localparam logic [CNT_W-1:0] CNT_MSG_MAX = 13'h0FF0;
  localparam logic [CNT_W-1:0] CNT_ALL_MAX = 13'h1000;
  localparam logic [IDX_W-1:0] IDX_LAST = 3'h4;
  // ---------------------------------------------------------------
  // packets and translation annex
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PK_MSG = 2'h0,
    PK_ACK = 2'h1,
    PK_NACK = 2'h2,
    PK_ERR = 2'h3
  } mqb_kind_e;
  localparam int FC_W = 2;
  localparam logic [FC_W-1:0] FC_MSG = 2'h2;
  localparam int ANNEX_N = 8;
  localparam int ANNEX_IW = 3;
  // ---------------------------------------------------------------
  // software register map (word indices)
  // ---------------------------------------------------------------
  localparam int RA_W = 8;
  localparam int RD_W = 32;
  localparam logic [RA_W-1:0] RA_SYNC0 = 8'h00;
  localparam logic [RA_W-1:0] RA_SYNC1 = 8'h01;
  localparam logic [RA_W-1:0] RA_MODE = 8'h02;
  localparam logic [RA_W-1:0] RA_IEN = 8'h03;
  localparam logic [RA_W-1:0] RA_IPEND = 8'h04;
  localparam logic [RA_W-1:0] RA_QHEAD = 8'h05;
  localparam logic [RA_W-1:0] RA_QCNT = 8'h06;
  localparam logic [RA_W-1:0] RA_QPOP = 8'h07;
  localparam logic [RA_W-1:0] RA_STAT = 8'h08;
  localparam logic [RA_W-1:0] RA_ANNEX = 8'h10;
  localparam int IRQ_N = SYNC_BITS + 1;
  localparam int IRQ_MSG = 16;
endpackage : mqb_pkg

/* design/mqb_if.sv */
// link between the support logic and the processor/network end
`timescale 1ns/10ps
interface mqb_if;
  import mqb_pkg::*;
  // processor write-buffer line
  logic wb_valid;
  logic wb_ready;
  logic [ANNEX_IW-1:0] wb_index;
  logic [MSG_WORDS*W-1:0] wb_data;
  // incoming packets
  logic rx_valid;
  logic rx_ready;
  mqb_kind_e rx_kind;
  logic [NODE_W-1:0] rx_src;
  logic rx_err;
  logic [MSG_WORDS*W-1:0] rx_data;
  // outgoing packets
  logic tx_valid;
  logic tx_ready;
  mqb_kind_e tx_kind;
  logic [NODE_W-1:0] tx_dest;
  logic [MSG_WORDS*W-1:0] tx_data;

  modport dev (
    input wb_valid, wb_index, wb_data, rx_valid, rx_kind, rx_src, rx_err,
    input rx_data, tx_ready,
    output wb_ready, rx_ready, tx_valid, tx_kind, tx_dest, tx_data
  );
  modport node (
    output wb_valid, wb_index, wb_data, rx_valid, rx_kind, rx_src, rx_err,
    output rx_data, tx_ready,
    input wb_ready, rx_ready, tx_valid, tx_kind, tx_dest, tx_data
  );
endinterface : mqb_if

/* design/mqb_node_end.sv */
// processor write-buffer and network end of the messaging link
`timescale 1ns/10ps
module mqb_node_end #(
  parameter logic [mqb_pkg::NODE_W-1:0] MY_NODE = 3'h0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // link to the support logic
  mqb_if.node lnk,
  // processor write-buffer line
  input wire logic cpu_wr_valid,
  input wire logic [mqb_pkg::ANNEX_IW-1:0] cpu_wr_index,
  input wire logic [mqb_pkg::MSG_WORDS*mqb_pkg::W-1:0] cpu_wr_data,
  output logic cpu_wr_ready,
  // packets from the network
  input wire logic net_rx_valid,
  input wire logic [1:0] net_rx_kind,
  input wire logic [mqb_pkg::NODE_W-1:0] net_rx_src,
  input wire logic [mqb_pkg::NODE_W-1:0] net_rx_dest,
  input wire logic [mqb_pkg::MSG_WORDS*mqb_pkg::W-1:0] net_rx_data,
  input wire logic [mqb_pkg::PAR_W-1:0] net_rx_par,
  output logic net_rx_ready,
  // packets to the network
  output logic net_tx_valid,
  output logic [1:0] net_tx_kind,
  output logic [mqb_pkg::NODE_W-1:0] net_tx_dest,
  output logic [mqb_pkg::MSG_WORDS*mqb_pkg::W-1:0] net_tx_data,
  output logic [mqb_pkg::PAR_W-1:0] net_tx_par,
  input wire logic net_tx_ready
);
  import mqb_pkg::*;

  logic wb_valid_q;
  logic rx_valid_q;
  logic [PAR_W-1:0] par_in;
  logic [PAR_W-1:0] par_out;

  // one even-parity bit per data word, both directions
  genvar g;
  generate
    for (g = 0; g < PAR_W; g++) begin : g_par
      assign par_in[g] = ^net_rx_data[g*W +: W];
      assign par_out[g] = ^lnk.tx_data[g*W +: W];
    end
  endgenerate

  // ---------------------------------------------------------------
  // write-buffer line: one line held until the support logic takes it
  // ---------------------------------------------------------------
  assign lnk.wb_valid = wb_valid_q;
  assign cpu_wr_ready = ~wb_valid_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wb_valid_q <= 1'b0;
    end else if (cpu_wr_valid && !wb_valid_q) begin
      wb_valid_q <= 1'b1;
    end else if (lnk.wb_ready) begin
      wb_valid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lnk.wb_index <= '0;
      lnk.wb_data <= '0;
    end else if (cpu_wr_valid && !wb_valid_q) begin
      lnk.wb_index <= cpu_wr_index;
      lnk.wb_data <= cpu_wr_data;
    end
  end

  // ---------------------------------------------------------------
  // receive side: bad route or parity turns a packet into an error
  // ---------------------------------------------------------------
  assign lnk.rx_valid = rx_valid_q;
  assign net_rx_ready = ~rx_valid_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_valid_q <= 1'b0;
    end else if (net_rx_valid && !rx_valid_q) begin
      rx_valid_q <= 1'b1;
    end else if (lnk.rx_ready) begin
      rx_valid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lnk.rx_kind <= PK_MSG;
      lnk.rx_src <= '0;
      lnk.rx_err <= 1'b0;
      lnk.rx_data <= '0;
    end else if (net_rx_valid && !rx_valid_q) begin
      lnk.rx_src <= net_rx_src;
      lnk.rx_data <= net_rx_data;
      if (net_rx_dest != MY_NODE || par_in != net_rx_par) begin
        lnk.rx_kind <= PK_ERR;
        lnk.rx_err <= 1'b1;
      end else begin
        lnk.rx_kind <= mqb_kind_e'(net_rx_kind);
        lnk.rx_err <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // transmit side: single register stage toward the network
  // ---------------------------------------------------------------
  assign lnk.tx_ready = ~net_tx_valid | net_tx_ready;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      net_tx_valid <= 1'b0;
      net_tx_kind <= 2'h0;
      net_tx_dest <= '0;
      net_tx_data <= '0;
      net_tx_par <= '0;
    end else if (lnk.tx_ready) begin
      net_tx_valid <= lnk.tx_valid;
      net_tx_kind <= lnk.tx_kind;
      net_tx_dest <= lnk.tx_dest;
      net_tx_data <= lnk.tx_data;
      net_tx_par <= par_out;
    end
  end
endmodule : mqb_node_end

/* design/mqb_support.sv */
// per-node support logic: message queue, message send/reply, sync bits
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
// ---------------------------------------------------------------
// global combining tree for one sync circuit (and-tree, fan-out)
// ---------------------------------------------------------------
module mqb_sync_tree #(
  parameter int N = mqb_pkg::NODES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // per-node bit and participation mask
  input wire logic [N-1:0] node_bit,
  input wire logic [N-1:0] node_in_part,
  // broadcast back to every node
  output logic [N-1:0] bcast
);
  logic [2*N-2:0] and_t;
  logic [2*N-2:0] fan_t;

  // leaves outside the partition read as arrived
  assign and_t[2*N-2:N-1] = node_bit | ~node_in_part;
  assign fan_t[0] = and_t[0];
  genvar i;
  generate
    for (i = 0; i < N - 1; i++) begin : g_lvl
      assign and_t[i] = and_t[2*i+1] & and_t[2*i+2];
      assign fan_t[2*i+1] = fan_t[i];
      assign fan_t[2*i+2] = fan_t[i];
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bcast <= '0;
    end else begin
      bcast <= fan_t[2*N-2:N-1];
    end
  end
endmodule : mqb_sync_tree

module mqb_support #(
  parameter logic [mqb_pkg::MEM_AW-1:0] QBASE = 18'h00000
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // link to the processor/network end
  mqb_if.dev lnk,
  // software register port
  input wire logic [mqb_pkg::RA_W-1:0] sw_addr,
  input wire logic [mqb_pkg::RD_W-1:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [mqb_pkg::RD_W-1:0] sw_rdata,
  output logic irq,
  // local memory write port for the queue region
  output logic mem_we,
  output logic [mqb_pkg::MEM_AW-1:0] mem_addr,
  output logic [mqb_pkg::W-1:0] mem_wdata,
  // sync circuits
  output logic [mqb_pkg::SYNC_BITS-1:0] sync_out,
  input wire logic [mqb_pkg::SYNC_BITS-1:0] sync_bcast
);
  import mqb_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_STORE = 4'h2,
    S_REPLY = 4'h4,
    S_SEND = 4'h8
  } mqb_state_e;

  mqb_state_e state_q;
  logic [SYNC_BITS-1:0] mode_q;
  logic [SYNC_BITS-1:0] bc_prev_q;
  logic [SYNC_BITS-1:0] sync_done;
  logic [IRQ_N-1:0] ien_q;
  logic [IRQ_N-1:0] ipend_q;
  logic [IRQ_N-1:0] ev;
  logic [FC_W+NODE_W-1:0] annex_q [ANNEX_N];
  logic [PTR_W-1:0] head_q;
  logic [PTR_W-1:0] tail_q;
  logic [CNT_W-1:0] cnt_q;
  logic [IDX_W-1:0] widx_q;
  logic pend_q;
  logic nack_seen_q;
  mqb_kind_e cur_kind_q;
  mqb_kind_e rep_kind_q;
  logic [NODE_W-1:0] cur_src_q;
  logic [MSG_WORDS*W-1:0] cur_data_q;
  logic [NODE_W-1:0] snd_dest_q;
  logic [MSG_WORDS*W-1:0] snd_data_q;
  logic rx_take;
  logic wb_take;
  logic push;
  logic pop;
  logic fits;
  logic wr_sync0;
  logic wr_sync1;

  assign lnk.rx_ready = state_q == S_IDLE;
  assign lnk.wb_ready = state_q == S_IDLE && !pend_q && !lnk.rx_valid;
  assign rx_take = lnk.rx_valid && state_q == S_IDLE;
  assign wb_take = lnk.wb_valid && lnk.wb_ready;
  assign push = state_q == S_STORE && widx_q == IDX_LAST;
  assign pop = sw_wr && sw_addr == RA_QPOP && cnt_q != '0;
  // spare slots are kept for error packets; an error packet is dropped only once all 4096 slots are full
  assign fits = lnk.rx_kind == PK_ERR ? cnt_q < CNT_ALL_MAX
                                      : cnt_q < CNT_MSG_MAX;
  assign wr_sync0 = sw_wr && sw_addr == RA_SYNC0;
  assign wr_sync1 = sw_wr && sw_addr == RA_SYNC1;

  // ---------------------------------------------------------------
  // message receive, reply and send sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= S_IDLE;
      widx_q <= '0;
      pend_q <= 1'b0;
      nack_seen_q <= 1'b0;
      cur_kind_q <= PK_MSG;
      rep_kind_q <= PK_ACK;
      cur_src_q <= '0;
      cur_data_q <= '0;
      snd_dest_q <= '0;
      snd_data_q <= '0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (rx_take) begin
            cur_kind_q <= lnk.rx_kind;
            cur_src_q <= lnk.rx_src;
            cur_data_q <= lnk.rx_data;
            widx_q <= '0;
            if (lnk.rx_kind == PK_ACK) begin
              pend_q <= 1'b0;
            end else if (lnk.rx_kind == PK_NACK) begin
              nack_seen_q <= 1'b1;
              state_q <= S_SEND;
            end else if (fits) begin
              state_q <= S_STORE;
            end else if (lnk.rx_kind == PK_MSG) begin
              rep_kind_q <= PK_NACK;
              state_q <= S_REPLY;
            end
          end else if (wb_take && annex_q[lnk.wb_index][NODE_W +: FC_W]
                       == FC_MSG) begin
            snd_dest_q <= annex_q[lnk.wb_index][NODE_W-1:0];
            snd_data_q <= lnk.wb_data;
            pend_q <= 1'b1;
            state_q <= S_SEND;
          end
        end
        S_STORE: begin
          widx_q <= widx_q + 3'h1;
          if (push) begin
            rep_kind_q <= PK_ACK;
            state_q <= cur_kind_q == PK_MSG ? S_REPLY : S_IDLE;
          end
        end
        S_REPLY: begin
          if (!lnk.tx_valid) begin
            state_q <= S_IDLE;
          end
        end
        S_SEND: begin
          if (!lnk.tx_valid) begin
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // one outgoing packet register shared by replies and sends
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lnk.tx_valid <= 1'b0;
      lnk.tx_kind <= PK_MSG;
      lnk.tx_dest <= '0;
      lnk.tx_data <= '0;
    end else if (state_q == S_REPLY && !lnk.tx_valid) begin
      lnk.tx_valid <= 1'b1;
      lnk.tx_kind <= rep_kind_q;
      lnk.tx_dest <= cur_src_q;
      lnk.tx_data <= cur_data_q;
    end else if (state_q == S_SEND && !lnk.tx_valid) begin
      lnk.tx_valid <= 1'b1;
      lnk.tx_kind <= PK_MSG;
      lnk.tx_dest <= snd_dest_q;
      lnk.tx_data <= snd_data_q;
    end else if (lnk.tx_ready) begin
      lnk.tx_valid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // queue in local memory: header word then four data words
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mem_we <= 1'b0;
      mem_addr <= '0;
      mem_wdata <= '0;
    end else begin
      mem_we <= state_q == S_STORE;
      mem_addr <= QBASE + {tail_q, widx_q, {BYTE_W{1'b0}}};
      if (widx_q == '0) begin
        mem_wdata <= W'({cur_kind_q, cur_src_q});
      end else begin
        mem_wdata <= cur_data_q[(widx_q - 3'h1) * W +: W];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tail_q <= '0;
      head_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        tail_q <= tail_q + 12'h001;
      end
      if (pop) begin
        head_q <= head_q + 12'h001;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 13'h0001;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 13'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // sync bits: sixteen identical per-bit completion detectors
  // ---------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < SYNC_BITS; b++) begin : g_sync
      // a new arrival written in the same cycle as a completion wins
      assign sync_done[b] = mode_q[b]
          ? (bc_prev_q[b] && !sync_bcast[b])
          : (sync_out[b] && sync_bcast[b] && !bc_prev_q[b]);
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          sync_out[b] <= 1'b0;
          bc_prev_q[b] <= 1'b0;
        end else begin
          bc_prev_q[b] <= sync_bcast[b];
          if ((b < BANK_BITS) ? wr_sync0 : wr_sync1) begin
            sync_out[b] <= sw_wdata[b % BANK_BITS];
          end else if (sync_done[b]) begin
            sync_out[b] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // interrupt pending flags: write one to clear, a new event wins
  // ---------------------------------------------------------------
  assign ev = {push, sync_done} & ien_q;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ipend_q <= '0;
      irq <= 1'b0;
    end else begin
      if (sw_wr && sw_addr == RA_IPEND) begin
        ipend_q <= (ipend_q & ~sw_wdata[IRQ_N-1:0]) | ev;
      end else begin
        ipend_q <= ipend_q | ev;
      end
      irq <= |(ipend_q & ien_q);
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_q <= '0;
      ien_q <= '0;
      for (int k = 0; k < ANNEX_N; k++) begin
        annex_q[k] <= '0;
      end
    end else if (sw_wr) begin
      if (sw_addr == RA_MODE) begin
        mode_q <= sw_wdata[SYNC_BITS-1:0];
      end
      if (sw_addr == RA_IEN) begin
        ien_q <= sw_wdata[IRQ_N-1:0];
      end
      if (sw_addr[RA_W-1:ANNEX_IW] == RA_ANNEX[RA_W-1:ANNEX_IW]) begin
        annex_q[sw_addr[ANNEX_IW-1:0]] <= sw_wdata[FC_W+NODE_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sw_rdata <= '0;
    end else if (sw_rd) begin
      sw_rdata <= '0;
      case (sw_addr)
        RA_SYNC0: sw_rdata <= RD_W'(sync_out[BANK_BITS-1:0]);
        RA_SYNC1: sw_rdata <= RD_W'(sync_out[SYNC_BITS-1:BANK_BITS]);
        RA_MODE: sw_rdata <= RD_W'(mode_q);
        RA_IEN: sw_rdata <= RD_W'(ien_q);
        RA_IPEND: sw_rdata <= RD_W'(ipend_q);
        RA_QHEAD: sw_rdata <= RD_W'(head_q);
        RA_QCNT: sw_rdata <= RD_W'(cnt_q);
        RA_STAT: sw_rdata <= RD_W'({nack_seen_q, pend_q});
        default: begin
          if (sw_addr[RA_W-1:ANNEX_IW] == RA_ANNEX[RA_W-1:ANNEX_IW]) begin
            sw_rdata <= RD_W'(annex_q[sw_addr[ANNEX_IW-1:0]]);
          end
        end
      endcase
    end
  end
endmodule : mqb_support

/* verification/mqb_link_properties.sv */
// link checker between the support logic and the node end
`timescale 1ns/10ps
module mqb_link_properties (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // write-buffer line
  input wire logic wb_valid,
  input wire logic wb_ready,
  input wire logic [255:0] wb_data,
  // incoming packets
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire mqb_pkg::mqb_kind_e rx_kind,
  input wire logic [2:0] rx_src,
  input wire logic [255:0] rx_data,
  // outgoing packets
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire mqb_pkg::mqb_kind_e tx_kind,
  input wire logic [2:0] tx_dest,
  input wire logic [255:0] tx_data
);
  import mqb_pkg::*;
  logic [2:0] src_q;
  logic [255:0] data_q;
  wire logic take = rx_valid && rx_ready;
  // last taken packet, so replies can be matched to it
  always_ff @(posedge clk_sys) begin
    if (take) begin
      src_q <= rx_src;
      data_q <= rx_data;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_msg_sent: assert property (wb_valid && wb_ready ##2 tx_valid |->
    tx_kind == PK_MSG && tx_data == $past(wb_data, 2))
    else $error("message packet differs from the written line");
  a_msg_reply: assert property (take && rx_kind == PK_MSG |->
    ##[2:16] tx_valid && (tx_kind == PK_ACK || tx_kind == PK_NACK))
    else $error("received message got no reply");
  a_ack_src: assert property ($rose(tx_valid) && tx_kind == PK_ACK |->
    tx_dest == src_q && tx_data == data_q)
    else $error("acknowledge sent to wrong node");
  a_nack_echo: assert property ($rose(tx_valid) && tx_kind == PK_NACK |->
    tx_dest == src_q && tx_data == data_q)
    else $error("refusal does not return the message");
  a_nack_resend: assert property (take && rx_kind == PK_NACK |->
    ##[1:8] tx_valid && tx_kind == PK_MSG && tx_data == data_q)
    else $error("refused message not sent again");
  a_err_silent: assert property (take && rx_kind == PK_ERR |->
    ##1 !tx_valid [*8])
    else $error("error packet answered");
  a_one_out: assert property (wb_valid && wb_ready |=> !wb_ready [*4])
    else $error("second line taken before reply");
  a_store_busy: assert property (take && rx_kind inside {PK_MSG, PK_ERR}
    |=> !rx_ready ##1 (!rx_ready || tx_valid && tx_kind == PK_NACK))
    else $error("packet taken while storing");
  a_tx_stands: assert property (tx_valid && !tx_ready |=> tx_valid &&
    $stable(tx_data) && $stable(tx_dest))
    else $error("outgoing packet dropped or changed");
endmodule : mqb_link_properties

/* verification/message_queue_and_barrier_sync_tb.sv */
// bench joining support logic and node end over the link interface
`timescale 1ns/10ps
module message_queue_and_barrier_sync_tb;
  import mqb_pkg::*;
  localparam int DW = MSG_WORDS * W;
  localparam int EW = DW + 5;
  logic clk_sys, reset, cpu_wr_valid, cpu_wr_ready, net_rx_valid, irq;
  logic net_rx_ready, net_tx_valid, sw_wr, sw_rd, mem_we;
  logic net_tx_ready = 1'b0;
  logic rd_seen = 1'b0;
  logic [2:0] cpu_wr_index, net_rx_src, net_rx_dest, net_tx_dest, s;
  logic [1:0] net_rx_kind, net_tx_kind;
  logic [3:0] net_rx_par, net_tx_par;
  logic [DW-1:0] cpu_wr_data, net_rx_data, net_tx_data, d;
  logic [7:0] sw_addr;
  logic [31:0] sw_wdata, sw_rdata;
  logic [17:0] mem_addr;
  logic [63:0] mem_wdata;
  logic [15:0] sync_out, sync_bcast, v;
  logic [7:0] t_bit, t_part, t_out, t_exp;
  logic [EW-1:0] tq[$], mq[$], rq[$];
  int err_total, checks_done, seed;

  mqb_if lnk();
  mqb_support i_mqb_support (.clk_sys(clk_sys), .reset(reset), .lnk(lnk),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .irq(irq), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .sync_out(sync_out), .sync_bcast(sync_bcast));
  mqb_node_end i_mqb_node_end (.clk_sys(clk_sys), .reset(reset), .lnk(lnk),
    .cpu_wr_valid(cpu_wr_valid), .cpu_wr_index(cpu_wr_index),
    .cpu_wr_data(cpu_wr_data), .cpu_wr_ready(cpu_wr_ready),
    .net_rx_valid(net_rx_valid), .net_rx_kind(net_rx_kind),
    .net_rx_src(net_rx_src), .net_rx_dest(net_rx_dest),
    .net_rx_data(net_rx_data), .net_rx_par(net_rx_par),
    .net_rx_ready(net_rx_ready), .net_tx_valid(net_tx_valid),
    .net_tx_kind(net_tx_kind), .net_tx_dest(net_tx_dest),
    .net_tx_data(net_tx_data), .net_tx_par(net_tx_par),
    .net_tx_ready(net_tx_ready));
  mqb_link_properties i_mqb_link_properties (.clk_sys(clk_sys),
    .reset(reset), .wb_valid(lnk.wb_valid), .wb_ready(lnk.wb_ready),
    .wb_data(lnk.wb_data), .rx_valid(lnk.rx_valid), .rx_ready(lnk.rx_ready),
    .rx_kind(lnk.rx_kind), .rx_src(lnk.rx_src), .rx_data(lnk.rx_data),
    .tx_valid(lnk.tx_valid), .tx_ready(lnk.tx_ready),
    .tx_kind(lnk.tx_kind), .tx_dest(lnk.tx_dest), .tx_data(lnk.tx_data));
  mqb_sync_tree i_mqb_sync_tree (.clk_sys(clk_sys), .reset(reset),
    .node_bit(t_bit), .node_in_part(t_part), .bcast(t_out));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic stop_test(input bit hung);
    if (hung) err_total++;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [EW-1:0] v, e);
    checks_done++;
    if (v !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, e, v);
    end
  endtask : chk
  function automatic logic [EW-1:0] pop(ref logic [EW-1:0] q[$]);
    return q.size() != 0 ? q.pop_front() : 'x;
  endfunction : pop
  function automatic logic [DW-1:0] rnd();
    for (int i = 0; i < DW / 32; i++) rnd[i*32+:32] = $random(seed);
  endfunction : rnd
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= 1'b1;
    @(posedge clk_sys);
    sw_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    sw_addr <= a;
    sw_rd <= 1'b1;
    rq.push_back(EW'(e));
    @(posedge clk_sys);
    sw_rd <= 1'b0;
  endtask : rd
  // a packet from the network; waits until earlier expected outgoing packets have left
  task automatic rx(input logic [1:0] k, input logic [2:0] src, dst,
                    input logic [DW-1:0] x, input logic bad);
    int n;
    n = 0;
    @(posedge clk_sys);
    while (tq.size() != 0 && ++n < 400) @(posedge clk_sys);
    net_rx_valid <= 1'b1;
    net_rx_kind <= k;
    net_rx_src <= src;
    net_rx_dest <= dst;
    net_rx_data <= x;
    for (int g = 0; g < 4; g++) net_rx_par[g] <= ^x[g*W+:W] ^ bad;
    do @(posedge clk_sys); while (!net_rx_ready && ++n < 400);
    net_rx_valid <= 1'b0;
    if (n >= 400) stop_test(1);
  endtask : rx
  task automatic store(input int slot, input logic [1:0] k,
                       input logic [2:0] src, input logic [DW-1:0] x);
    logic [17:0] a;
    a = 18'(slot * SLOT_BYTES);
    mq.push_back(EW'({a, 64'({k, src})}));
    for (int j = 0; j < 4; j++)
      mq.push_back(EW'({a + 18'(8 * j + 8), x[j*W+:W]}));
  endtask : store
  // every noted result must have appeared before counts are read
  task automatic drain();
    for (int n = 0; tq.size() + mq.size() + rq.size() != 0; n++) begin
      if (n == 400) stop_test(1);
      @(posedge clk_sys);
    end
  endtask : drain

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // results are matched to the oldest expectation of their kind
  always @(posedge clk_sys) begin
    net_tx_ready <= ($random(seed) & 3) != 0;
    rd_seen <= sw_rd;
    if (net_tx_valid && net_tx_ready)
      chk("tx", {net_tx_kind, net_tx_dest, net_tx_data}, pop(tq));
    if (mem_we) chk("mem", EW'({mem_addr, mem_wdata}), pop(mq));
    if (rd_seen) chk("rdata", EW'(sw_rdata), pop(rq));
  end

  initial begin
    seed = 32'h1448;
    {cpu_wr_valid, cpu_wr_index, cpu_wr_data, net_rx_valid, net_rx_kind,
     net_rx_src, net_rx_dest, net_rx_data, net_rx_par, sw_addr, sw_wdata,
     sw_wr, sw_rd, sync_bcast, t_bit, t_part} = '0;
    reset = 1'b1;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    rd(RA_SYNC0, 32'h0);
    rd(RA_QCNT, 32'h0);
    rd(8'h20, 32'h0);
    wr(RA_IEN, 32'h0001_0003);
    wr(RA_ANNEX, {27'h0, FC_MSG, 3'h5});
    d = rnd();
    @(posedge clk_sys);
    cpu_wr_valid <= 1'b1;
    cpu_wr_data <= d;
    for (int n = 0; n == 0 || !cpu_wr_ready; n++) begin
      if (n == 400) stop_test(1);
      @(posedge clk_sys);
    end
    cpu_wr_valid <= 1'b0;
    tq.push_back({PK_MSG, 3'h5, d});
    rx(PK_NACK, 3'h5, 3'h0, d, 1'b0);
    tq.push_back({PK_MSG, 3'h5, d});
    rx(PK_ACK, 3'h5, 3'h0, d, 1'b0);
    rd(RA_STAT, 32'h2);
    // fill the queue, one refused, then a misrouted and a corrupt packet
    for (int i = 0; i <= QSLOTS + 2; i++) begin
      s = i[2:0];
      d = rnd();
      rx(PK_MSG, s, i == QSLOTS + 1 ? 3'h6 : 3'h0, d, i == QSLOTS + 2);
      if (i < QSLOTS) tq.push_back({PK_ACK, s, d});
      if (i == QSLOTS) tq.push_back({PK_NACK, s, d});
      if (i < QSLOTS) store(i, PK_MSG, s, d);
      if (i > QSLOTS) store(i - 1, PK_ERR, s, d);
    end
    drain();
    rd(RA_QCNT, QSLOTS + 2);
    rd(RA_IPEND, 32'h0001_0000);
    chk("irq", EW'(irq), EW'(1));
    wr(RA_QPOP, 32'h0);
    rd(RA_QHEAD, 32'h1);
    wr(RA_IPEND, 32'h0001_0000);
    rd(RA_IPEND, 32'h0);
    chk("irq", EW'(irq), EW'(0));
    wr(RA_SYNC0, 32'h1);
    wr(RA_SYNC1, 32'h1);
    @(posedge clk_sys);
    chk("sync", EW'(sync_out), EW'(16'h0101));
    sync_bcast <= 16'h0101;
    rd(RA_SYNC0, 32'h0);
    rd(RA_SYNC1, 32'h0);
    rd(RA_IPEND, 32'h1);
    wr(RA_SYNC0, 32'h1);
    rd(RA_SYNC0, 32'h1);
    wr(RA_MODE, 32'h2);
    wr(RA_SYNC0, 32'h2);
    sync_bcast <= 16'h0002;
    rd(RA_SYNC0, 32'h2);
    sync_bcast <= 16'h0000;
    rd(RA_SYNC0, 32'h0);
    rd(RA_IPEND, 32'h3);
    // combining tree: all arrived, one missing, a partition, then random
    for (int i = 0; i < 8; i++) begin
      v = i == 0 ? 16'hFFFF : i == 1 ? 16'hFF7F : i == 2 ? 16'h0F0F
          : 16'($random(seed));
      t_exp = {8{&(v[7:0] | ~v[15:8])}};
      @(posedge clk_sys);
      {t_part, t_bit} <= v;
      repeat (2) @(posedge clk_sys);
      chk("tree", EW'(t_out), EW'(t_exp));
    end
    drain();
    stop_test(0);
  end
endmodule : message_queue_and_barrier_sync_tb
